// file: verilog/dmass_defines.svh
// register offsets, bit positions and reset values of the dma status and steering block
// assumes a 16-bit byte address and 8-bit data on the register port
`ifndef DMASS_DEFINES_SVH
`define DMASS_DEFINES_SVH

`define DMASS_AW              16
`define DMASS_DW              8
`define DMASS_CW              16

`define DMASS_A_C0_IRQ_EN     16'hff29
`define DMASS_A_C0_FLAGS      16'hff2a
`define DMASS_A_C0_PEND_LO    16'hff32
`define DMASS_A_C0_PEND_HI    16'hff33
`define DMASS_A_C1_IRQ_EN     16'hff3d
`define DMASS_A_C1_FLAGS      16'hff3e
`define DMASS_A_C1_PEND_LO    16'hff46
`define DMASS_A_C1_PEND_HI    16'hff47
`define DMASS_A_CRC_LO        16'hff48
`define DMASS_A_CRC_HI        16'hff49
`define DMASS_A_STEER_BASE    16'hff50

`define DMASS_B_TC            0
`define DMASS_B_INIT          1
`define DMASS_B_OVF           2

`define DMASS_B_SEL_HI        5
`define DMASS_B_EN_HI         4
`define DMASS_B_SEL_LO        1
`define DMASS_B_EN_LO         0

`define DMASS_RST_BYTE        8'h00
`define DMASS_RST_CNT         16'h0000
`define DMASS_RST_CRC         16'h0000
`define DMASS_CNT_FULL        16'hffff
`define DMASS_CRC_POLY        16'h1021

`endif

// file: verilog/dmass_pkg.sv
// types shared by the dma status and steering block
// assumes dmass_defines.svh is on the include path
package dmass_pkg;

  // one channel's event flags or enables, bit order tc, init, ovf
  typedef struct packed {
    logic ovf;
    logic init;
    logic tc;
  } dmass_flags_s;

  // per-channel signals from the rest of the dma channel
  typedef struct packed {
    logic tc_hit;
    logic init_hit;
    logic init_bit_set;
    logic req_enable;
    logic wipe;
    logic crc_enable;
  } dmass_chev_s;

  // one steering register
  typedef struct packed {
    logic sel;
    logic en;
  } dmass_steer_s;

endpackage : dmass_pkg

// file: verilog/dmass_top.sv
// pending counters, event flags, interrupt lines, shared crc and
// request/acknowledge steering registers of a two-channel byte dma
// assumes a synchronous register port with read data one cycle later,
// and channel-side events as single-cycle pulses on i_clk
//
// Notes on behaviour
// - each channel counts requests taken but not yet acknowledged, 16 bits, read-only.
// - terminal-count enable lets the terminal-count event raise the channel interrupt.
// - init enable lets a transfer initialisation raise the channel interrupt.
// - overflow enable lets pending counter overflow raise the channel interrupt.
// - terminal-count flag set by hardware, also cleared when the init bit is set.
// - init flag set on initialisation, also cleared when software sets the init bit.
// - overflow flag set on counter overflow, also cleared whenever the counter clears.
// - software clears flags by writing one; writing zero leaves them alone.
// - interrupt flagged only when a flag and its enable are both set.
// - reset clears pending counters, enables, flags and the crc result.
// - one 16-bit crc signature, shared by both channels, readable by software.
// - steering select clear routes to channel 0, set to channel 1, same bit order in either nibble.
// - steering enable clear blocks requests and acknowledges of that peripheral.
// - undefined steering bits read zero; reset clears the steering register.
// - steering registers are single bytes at their own decoded addresses.
// - rising edge of either crc enable resets the shared crc to zero.
// - request enable rising clears the pending counter; while clear requests ignored.
// - wipe bit clears the pending counter and blocks request counting only while it is set.
`timescale 1ns/1ps
`include "dmass_defines.svh"

module dmass_top
  import dmass_pkg::*;
#(
  parameter int                  N_STEER      = 4,
  // bit n set: steering register n sits on the high data nibble
  parameter logic [N_STEER-1:0]  STEER_HI_NIB = 4'b1010,
  parameter logic [15:0]         CRC_POLY     = `DMASS_CRC_POLY
)
(
  input  wire logic                  i_clk,
  input  wire logic                  i_rstn,
  input  wire logic [`DMASS_AW-1:0]  i_addr,
  input  wire logic [`DMASS_DW-1:0]  i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  output logic      [`DMASS_DW-1:0]  o_rdata,
  input  wire dmass_chev_s [1:0]     i_chan_ev,
  input  wire logic [1:0]            i_chan_ack,
  input  wire logic                  i_crc_strobe,
  input  wire logic [7:0]            i_crc_data,
  output logic      [1:0]            o_chan_req,
  output logic      [1:0]            o_chan_irq,
  input  wire logic [N_STEER-1:0]    i_periph_request,
  output logic      [N_STEER-1:0]    o_periph_acknowledge
);

  // one crc byte step, msb first
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      if (r[15] ^ d[i])
        r = {r[14:0], 1'b0} ^ CRC_POLY;
      else
        r = {r[14:0], 1'b0};
    end
    return r;
  endfunction : crc_step

  // w1c flag update; the hardware set beats any clear in the same cycle
  function automatic logic flag_next(input logic q, input logic set, input logic clr);
    return set | (q & ~clr);
  endfunction : flag_next

  // steering register n decodes the byte n above the base
  function automatic logic steer_hit(input logic [`DMASS_AW-1:0] a, input int n);
    return a == (`DMASS_A_STEER_BASE + 16'(n));
  endfunction : steer_hit

  // write strobe aimed at one byte address; operands passed in so assigns see them change
  function automatic logic wr_at(input logic wr, input logic [`DMASS_AW-1:0] a, input logic [`DMASS_AW-1:0] at);
    return wr & (a == at);
  endfunction : wr_at

  // steered request for channel ch from all enabled steering registers
  function automatic logic steer_req(input logic [N_STEER-1:0] req,
                                     input dmass_steer_s [N_STEER-1:0] st,
                                     input logic ch);
    logic r;
    r = 1'b0;
    for (int n = 0; n < N_STEER; n++)
    begin
      r = r | (req[n] & st[n].en & (st[n].sel == ch));
    end
    return r;
  endfunction : steer_req

  logic [`DMASS_CW-1:0]        pend_q    [2];
  logic [`DMASS_CW-1:0]        pend_d    [2];
  dmass_flags_s [1:0]          flags_q;
  dmass_flags_s [1:0]          flags_d;
  dmass_flags_s [1:0]          irq_en_q;
  dmass_flags_s [1:0]          irq_en_d;
  logic [1:0]                  req_en_prev_q;
  logic [1:0]                  crc_en_prev_q;
  logic [15:0]                 crc_q;
  logic [15:0]                 crc_d;
  dmass_steer_s [N_STEER-1:0]  steer_q;
  dmass_steer_s [N_STEER-1:0]  steer_d;
  logic [`DMASS_DW-1:0]        rdata_d;
  logic [1:0]                  chan_req_d;
  logic [1:0]                  irq_d;
  logic [N_STEER-1:0]          ack_d;

  // address decode
  wire logic [1:0] wr_flags_w;
  wire logic [1:0] wr_irq_en_w;
  assign wr_flags_w[0]  = wr_at(i_wr, i_addr, `DMASS_A_C0_FLAGS);
  assign wr_flags_w[1]  = wr_at(i_wr, i_addr, `DMASS_A_C1_FLAGS);
  assign wr_irq_en_w[0] = wr_at(i_wr, i_addr, `DMASS_A_C0_IRQ_EN);
  assign wr_irq_en_w[1] = wr_at(i_wr, i_addr, `DMASS_A_C1_IRQ_EN);

  wire dmass_flags_s w1c_w;
  assign w1c_w = dmass_flags_s'({i_wdata[`DMASS_B_OVF], i_wdata[`DMASS_B_INIT], i_wdata[`DMASS_B_TC]});

  // crc enable edges are shared by both channels
  wire logic [1:0] crc_rise_w;
  assign crc_rise_w = {i_chan_ev[1].crc_enable, i_chan_ev[0].crc_enable} & ~crc_en_prev_q;
  wire logic crc_on_w;
  assign crc_on_w = i_chan_ev[0].crc_enable | i_chan_ev[1].crc_enable;

  for (genvar c = 0; c < 2; c++)
  begin : g_chan
    wire logic en_rise_w;
    wire logic cnt_clr_w;
    wire logic take_w;
    wire logic give_w;
    wire logic full_w;
    wire logic ovf_w;

    assign en_rise_w = i_chan_ev[c].req_enable & ~req_en_prev_q[c];
    assign cnt_clr_w = i_chan_ev[c].wipe | en_rise_w;
    assign take_w    = chan_req_d[c] & i_chan_ev[c].req_enable & ~i_chan_ev[c].wipe;
    assign give_w    = i_chan_ack[c] & (pend_q[c] != `DMASS_RST_CNT);
    assign full_w    = (pend_q[c] == `DMASS_CNT_FULL);
    assign ovf_w     = take_w & ~give_w & full_w & ~cnt_clr_w;

    // pending request count, held at full on overflow
    always_comb
    begin
      pend_d[c] = pend_q[c];
      if (cnt_clr_w)
        pend_d[c] = `DMASS_RST_CNT;
      else if (take_w & ~give_w & ~full_w)
        pend_d[c] = pend_q[c] + 16'h0001;
      else if (give_w & ~take_w)
        pend_d[c] = pend_q[c] - 16'h0001;
    end

    // tc set, cleared also by the init bit
    assign flags_d[c].tc   = flag_next(flags_q[c].tc, i_chan_ev[c].tc_hit,
                                       (wr_flags_w[c] & w1c_w.tc) | i_chan_ev[c].init_bit_set);
    // init set, cleared also by the init bit
    assign flags_d[c].init = flag_next(flags_q[c].init, i_chan_ev[c].init_hit,
                                       (wr_flags_w[c] & w1c_w.init) | i_chan_ev[c].init_bit_set);
    // ovf set, cleared also with the counter
    assign flags_d[c].ovf  = flag_next(flags_q[c].ovf, ovf_w,
                                       (wr_flags_w[c] & w1c_w.ovf) | cnt_clr_w);

    assign irq_en_d[c] = wr_irq_en_w[c] ? w1c_w : irq_en_q[c];

    wire dmass_flags_s armed_w;
    assign armed_w = flags_q[c] & irq_en_q[c];
    assign irq_d[c] = armed_w.tc | armed_w.init | armed_w.ovf;

    assign chan_req_d[c] = steer_req(i_periph_request, steer_q, 1'(c));
  end : g_chan

  always_comb
  begin
    crc_d = crc_q;
    if (|crc_rise_w)
      crc_d = `DMASS_RST_CRC;
    else if (crc_on_w & i_crc_strobe)
      crc_d = crc_step(crc_q, i_crc_data);
  end

  // steering registers, one nibble each
  for (genvar n = 0; n < N_STEER; n++)
  begin : g_steer
    wire logic hit_w;
    wire logic sel_bit_w;
    wire logic en_bit_w;
    // one byte at its own address
    assign hit_w     = steer_hit(i_addr, n);
    assign sel_bit_w = STEER_HI_NIB[n] ? i_wdata[`DMASS_B_SEL_HI] : i_wdata[`DMASS_B_SEL_LO];
    assign en_bit_w  = STEER_HI_NIB[n] ? i_wdata[`DMASS_B_EN_HI] : i_wdata[`DMASS_B_EN_LO];
    assign steer_d[n] = (i_wr & hit_w) ? dmass_steer_s'({sel_bit_w, en_bit_w}) : steer_q[n];
    assign ack_d[n] = steer_q[n].en & i_chan_ack[steer_q[n].sel];
  end : g_steer

  // steering readback on the attached nibble only
  function automatic logic [7:0] steer_byte(input dmass_steer_s s, input logic hi);
    logic [7:0] b;
    b = `DMASS_RST_BYTE;
    if (hi)
    begin
      b[`DMASS_B_SEL_HI] = s.sel;
      b[`DMASS_B_EN_HI]  = s.en;
    end
    else
    begin
      b[`DMASS_B_SEL_LO] = s.sel;
      b[`DMASS_B_EN_LO]  = s.en;
    end
    return b;
  endfunction : steer_byte

  // steering readback; addresses never overlap, so one register at most
  logic [`DMASS_DW-1:0]        steer_rdata;
  always_comb
  begin
    steer_rdata = `DMASS_RST_BYTE;
    for (int n = 0; n < N_STEER; n++)
    begin
      if (steer_hit(i_addr, n))
        steer_rdata = steer_byte(steer_q[n], STEER_HI_NIB[n]);
    end
  end

  // read mux; unmapped addresses read zero
  always_comb
  begin
    rdata_d = `DMASS_RST_BYTE;
    if (i_rd)
    begin
      unique case (i_addr)
        `DMASS_A_C0_IRQ_EN:  rdata_d = {5'h00, irq_en_q[0]};
        `DMASS_A_C0_FLAGS:   rdata_d = {5'h00, flags_q[0]};
        `DMASS_A_C0_PEND_LO: rdata_d = pend_q[0][7:0];
        `DMASS_A_C0_PEND_HI: rdata_d = pend_q[0][15:8];
        `DMASS_A_C1_IRQ_EN:  rdata_d = {5'h00, irq_en_q[1]};
        `DMASS_A_C1_FLAGS:   rdata_d = {5'h00, flags_q[1]};
        `DMASS_A_C1_PEND_LO: rdata_d = pend_q[1][7:0];
        `DMASS_A_C1_PEND_HI: rdata_d = pend_q[1][15:8];
        `DMASS_A_CRC_LO:     rdata_d = crc_q[7:0];
        `DMASS_A_CRC_HI:     rdata_d = crc_q[15:8];
        default:             rdata_d = steer_rdata;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pend_q[0] <= `DMASS_RST_CNT;
      pend_q[1] <= `DMASS_RST_CNT;
    end
    else
    begin
      pend_q[0] <= pend_d[0];
      pend_q[1] <= pend_d[1];
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      flags_q <= '0;
    else
      flags_q <= flags_d;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      irq_en_q <= '0;
    else
      irq_en_q <= irq_en_d;
  end

  // rise detectors reset low like idle control bits, so no false edge
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      req_en_prev_q <= '0;
      crc_en_prev_q <= '0;
    end
    else
    begin
      req_en_prev_q <= {i_chan_ev[1].req_enable, i_chan_ev[0].req_enable};
      crc_en_prev_q <= {i_chan_ev[1].crc_enable, i_chan_ev[0].crc_enable};
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      crc_q <= `DMASS_RST_CRC;
    else
      crc_q <= crc_d;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      steer_q <= '0;
    else
      steer_q <= steer_d;
  end

  // read data stands for one cycle only
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_rdata <= `DMASS_RST_BYTE;
    else
      o_rdata <= rdata_d;
  end

  // steered requests, one flop after the peripheral
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_chan_req <= '0;
    else
      o_chan_req <= chan_req_d;
  end

  // interrupt lines, one flop after flag and enable
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_chan_irq <= '0;
    else
      o_chan_irq <= irq_d;
  end

  // acknowledges back to the fabric, one flop after the channel
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_periph_acknowledge <= '0;
    else
      o_periph_acknowledge <= ack_d;
  end

endmodule : dmass_top

// file: bench/dmass_top_monitor.sv
// checker: port-level assertions on the dma status and steering block
// assumes writes land at the edge that samples them; shadows channel 0 only
`timescale 1ns/1ps
`include "dmass_defines.svh"
module dmass_top_monitor
  import dmass_pkg::*;
#(
  parameter int                 N_STEER      = 4,
  parameter logic [N_STEER-1:0] STEER_HI_NIB = 4'b1010,
  parameter logic [15:0]        CRC_POLY     = 16'h1021
)
(
  input wire logic                 i_clk,
  input wire logic                 i_rstn,
  input wire logic [15:0]          i_addr,
  input wire logic [7:0]           i_wdata,
  input wire logic                 i_wr,
  input wire logic                 i_rd,
  input wire logic [7:0]           o_rdata,
  input wire dmass_chev_s [1:0]    i_chan_ev,
  input wire logic [1:0]           i_chan_ack,
  input wire logic [1:0]           o_chan_req,
  input wire logic [1:0]           o_chan_irq,
  input wire logic [N_STEER-1:0]   i_periph_request,
  input wire logic [N_STEER-1:0]   o_periph_acknowledge
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  logic [2:0]   en0_q;
  dmass_steer_s st0_q;
  wire          wr_en0 = i_wr && i_addr == `DMASS_A_C0_IRQ_EN;
  wire          wr_st0 = i_wr && i_addr == `DMASS_A_STEER_BASE;
  // shadows only; register 0 sits on the low nibble
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      en0_q <= 3'h0;
    else if (wr_en0)
      en0_q <= i_wdata[2:0];
  end
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      st0_q <= '0;
    else if (wr_st0)
      st0_q <= i_wdata[1:0];
  end
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside a read");
  enable_resv_a: assert property ($past(i_rd && i_addr == `DMASS_A_C0_IRQ_EN) |-> o_rdata[7:3] == 5'h00)
    else $error("reserved enable bits read nonzero");
  steer_read_a: assert property ($past(i_rd && wr_st0 == 1'b0 && i_addr == `DMASS_A_STEER_BASE)
    |-> o_rdata == {6'h00, $past(st0_q)})
    else $error("steering register read mismatch");
  req_steer_a: assert property (i_periph_request[0] && st0_q.en |=> o_chan_req[$past(st0_q.sel)])
    else $error("request not steered");
  req_cause_a: assert property (|o_chan_req |-> $past(|i_periph_request))
    else $error("request without a source");
  ack_steer_a: assert property (i_chan_ack[st0_q.sel] && st0_q.en |=> o_periph_acknowledge[0])
    else $error("acknowledge not steered");
  ack_blocked_a: assert property (!st0_q.en |=> !o_periph_acknowledge[0])
    else $error("acknowledge while steering disabled");
  irq_tc_a: assert property (i_chan_ev[0].tc_hit && en0_q[0] && !wr_en0 |-> ##2 o_chan_irq[0])
    else $error("terminal count interrupt missing");
  irq_off_a: assert property (en0_q == 3'h0 && $past(en0_q) == 3'h0 |-> !o_chan_irq[0])
    else $error("interrupt with all enables clear");
endmodule : dmass_top_monitor

bind dmass_top dmass_top_monitor #(.N_STEER(N_STEER), .STEER_HI_NIB(STEER_HI_NIB), .CRC_POLY(CRC_POLY)) mon_u (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_chan_ev(i_chan_ev), .i_chan_ack(i_chan_ack), .o_chan_req(o_chan_req),
  .o_chan_irq(o_chan_irq), .i_periph_request(i_periph_request),
  .o_periph_acknowledge(o_periph_acknowledge));

// file: bench/dmass_periph_model.sv
// model: fabric peripherals issuing request bursts and counting acknowledges
// assumes the bench loads one burst length at a time
`timescale 1ns/1ps
module dmass_periph_model
#(
  parameter int N = 4
)
(
  input  wire logic               i_clk,
  input  wire logic               i_rstn,
  input  wire logic               i_load,
  input  wire logic [1:0]         i_idx,
  input  wire logic [16:0]        i_count,
  input  wire logic [N-1:0]       i_acknowledge,
  output logic      [N-1:0]       o_request,
  output logic      [N-1:0][15:0] o_acks
);
  logic [N-1:0][16:0] left_q;
  always_comb
    for (int n = 0; n < N; n++)
      o_request[n] = left_q[n] != 17'h0;
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      left_q <= '0;
      o_acks <= '0;
    end
    else
      for (int n = 0; n < N; n++)
      begin
        if (i_load && i_idx == n)
          left_q[n] <= i_count;
        else if (left_q[n] != 17'h0)
          left_q[n] <= left_q[n] - 17'h1;
        if (i_acknowledge[n])
          o_acks[n] <= o_acks[n] + 16'h1;
      end
  end
endmodule : dmass_periph_model

// file: bench/dma_status_and_request_steering_bench.sv
// testbench: registers, steering, pending counts, flags, crc
// assumes the partner model drives the peripheral requests
`timescale 1ns/1ps
`include "dmass_defines.svh"
module dma_status_and_request_steering_bench;
  import dmass_pkg::*;
  localparam int TC = 5, IH = 4, IB = 3, RE = 2, WP = 1, CE = 0;
  logic              clk = 0, rstn = 0, wr = 0, rd = 0, stb = 0, ld = 0;
  logic [15:0]       addr = '0, cexp = '0;
  logic [7:0]        wdata = '0, cdat = '0, rdata;
  dmass_chev_s [1:0] ev = '0;
  logic [1:0]        ack = '0, creq, irq, idx = '0;
  logic [3:0]        preq, pack;
  logic [3:0][15:0]  acks;
  logic [16:0]       cnt = '0;
  int                num_errors = 0, comparisons = 0, n, k;
  dmass_top dut_u (.i_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_chan_ev(ev), .i_chan_ack(ack), .i_crc_strobe(stb), .i_crc_data(cdat),
    .o_chan_req(creq), .o_chan_irq(irq), .i_periph_request(preq), .o_periph_acknowledge(pack));
  dmass_periph_model per_u (.i_clk(clk), .i_rstn(rstn), .i_load(ld), .i_idx(idx), .i_count(cnt),
    .i_acknowledge(pack), .o_request(preq), .o_acks(acks));
  initial forever #25 clk = ~clk;
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic wrt(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrt
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk($sformatf("reg %h", a), {8'h00, rdata}, {8'h00, e});
  endtask : rdc
  task automatic rd16(input logic [15:0] a, input logic [15:0] e);
    rdc(a, e[7:0]);
    rdc(a + 16'h1, e[15:8]);
  endtask : rd16
  task automatic setv(input int c, input int f, input logic v);
    @(posedge clk);
    ev[c][f] <= v;
  endtask : setv
  task automatic pulse(input int c, input int f);
    setv(c, f, 1'b1);
    setv(c, f, 1'b0);
  endtask : pulse
  task automatic ackp(input int c);
    @(posedge clk);
    ack[c] <= 1'b1;
    @(posedge clk);
    ack[c] <= 1'b0;
  endtask : ackp
  task automatic burst(input int p, input logic [16:0] c);
    int i;
    @(posedge clk);
    idx <= p[1:0];
    cnt <= c;
    ld <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
    // the load lands at this edge; look only once it has settled
    @(negedge clk);
    for (i = 0; i < 70000 && preq[p]; i++)
      @(negedge clk);
    repeat (3) @(posedge clk);
    if (preq[p] !== 1'b0)
    begin
      num_errors++;
      $display("[ERR] burst end exp 0 got %b", preq[p]);
      end_of_test();
    end
  endtask : burst
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      c = (c << 1) ^ ((c[15] ^ d[i]) ? `DMASS_CRC_POLY : 16'h0);
    return c;
  endfunction : crc_step
  initial
  begin
    void'($urandom(32'ha27b));
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    for (k = 0; k < 16; k++)
      rdc(16'hff29 + k[15:0], 8'h00);
    n = $urandom;
    wrt(`DMASS_A_C1_IRQ_EN, n[7:0]);
    rdc(`DMASS_A_C1_IRQ_EN, {5'h0, n[2:0]});
    wrt(`DMASS_A_C1_PEND_LO, n[15:8]);
    rdc(`DMASS_A_C1_PEND_LO, 8'h00);
    // both nibbles alike, one register per channel and direction
    wrt(16'hff50, 8'h11);
    wrt(16'hff51, 8'h33);
    wrt(16'hff52, 8'hff);
    rdc(16'hff50, 8'h01);
    rdc(16'hff51, 8'h30);
    rdc(16'hff52, 8'h03);
    wrt(16'hff52, 8'h00);
    setv(0, RE, 1'b1);
    n = 1 + $urandom_range(300);
    burst(0, n[16:0]);
    rd16(`DMASS_A_C0_PEND_LO, n[15:0]);
    burst(1, 17'h5);
    rd16(`DMASS_A_C1_PEND_LO, 16'h0);
    k = $urandom_range(n);
    repeat (k) ackp(0);
    repeat (2) @(posedge clk);
    chk("acks0", acks[0], k[15:0]);
    chk("acks2", acks[2], 16'h0);
    rd16(`DMASS_A_C0_PEND_LO, n[15:0] - k[15:0]);
    setv(1, RE, 1'b1);
    burst(1, 17'h7);
    rd16(`DMASS_A_C1_PEND_LO, 16'h7);
    ackp(1);
    pulse(1, WP);
    rd16(`DMASS_A_C1_PEND_LO, 16'h0);
    chk("acks1", acks[1], 16'h1);
    wrt(`DMASS_A_C0_IRQ_EN, 8'h02);
    pulse(0, TC);
    rdc(`DMASS_A_C0_FLAGS, 8'h01);
    chk("irq0", {15'h0, irq[0]}, 16'h0);
    wrt(`DMASS_A_C0_FLAGS, 8'h00);
    pulse(0, IH);
    rdc(`DMASS_A_C0_FLAGS, 8'h03);
    chk("irq0", {15'h0, irq[0]}, 16'h1);
    wrt(`DMASS_A_C0_FLAGS, 8'h02);
    rdc(`DMASS_A_C0_FLAGS, 8'h01);
    chk("irq0", {15'h0, irq[0]}, 16'h0);
    wrt(`DMASS_A_C0_IRQ_EN, 8'h01);
    rdc(`DMASS_A_C0_IRQ_EN, 8'h01);
    chk("irq0", {15'h0, irq[0]}, 16'h1);
    pulse(0, IH);
    pulse(0, TC);
    pulse(0, IB);
    rdc(`DMASS_A_C0_FLAGS, 8'h00);
    wrt(`DMASS_A_C0_IRQ_EN, 8'h04);
    pulse(0, WP);
    burst(0, 17'h10000);
    rd16(`DMASS_A_C0_PEND_LO, 16'hffff);
    rdc(`DMASS_A_C0_FLAGS, 8'h04);
    chk("irq0", {15'h0, irq[0]}, 16'h1);
    setv(0, RE, 1'b0);
    setv(0, RE, 1'b1);
    rdc(`DMASS_A_C0_FLAGS, 8'h00);
    rd16(`DMASS_A_C0_PEND_LO, 16'h0);
    setv(0, CE, 1'b1);
    repeat (6)
    begin
      n = $urandom;
      @(posedge clk);
      stb <= 1'b1;
      cdat <= n[7:0];
      cexp = crc_step(cexp, n[7:0]);
    end
    @(posedge clk);
    stb <= 1'b0;
    rd16(`DMASS_A_CRC_LO, cexp);
    setv(1, CE, 1'b1);
    rd16(`DMASS_A_CRC_LO, 16'h0);
    end_of_test();
  end
endmodule : dma_status_and_request_steering_bench
